// ### hdl/dpr_pkg.sv
// Constants and types of the converter power and reset control block
package dpr_pkg;

    // ==========================================================
    // Clock and delay timing
    localparam int CLK_MHZ = 250;
    localparam int POWER_DOWN_ENTRY_DELAY_NS = 2000;
    localparam int POWER_DOWN_EXIT_DELAY_NS = 4000;
    localparam int RESET_RELEASE_DELAY_NS = 50000;
    // Least times round up to whole cycles
    localparam int POWER_DOWN_ENTRY_DELAY_CYC = (POWER_DOWN_ENTRY_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int POWER_DOWN_EXIT_DELAY_CYC = (POWER_DOWN_EXIT_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_RELEASE_DELAY_CYC = (RESET_RELEASE_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int TMR_W = 16;

    // ==========================================================
    // Data widths
    localparam int CODE_W = 12;
    localparam int PD_W = 2;
    localparam int REF_W = 2;
    localparam int BUS_W = 32;

    // ==========================================================
    // Power-down selection codes
    localparam logic [PD_W-1:0] PD_NORMAL = 2'h0;
    localparam logic [PD_W-1:0] PD_PULL_1K = 2'h1;
    localparam logic [PD_W-1:0] PD_PULL_125K = 2'h2;
    localparam logic [PD_W-1:0] PD_PULL_640K = 2'h3;

    // ==========================================================
    // Reset values
    localparam logic [CODE_W-1:0] CODE_CLEAR = 12'h000;
    localparam logic [REF_W-1:0] REF_CLEAR = 2'h0;
    localparam logic [PD_W-1:0] NV_PD_RESET = 2'h0;

    // ==========================================================
    // Decoded serial commands
    typedef enum logic [2:0] {
        CMD_WR_VOL_DAC = 3'h0,
        CMD_WR_VOL_MEM = 3'h1,
        CMD_WR_ALL_MEM = 3'h2,
        CMD_WR_VOL_CFG = 3'h3,
        CMD_GC_RESET = 3'h4,
        CMD_GC_WAKE = 3'h5,
        CMD_READ = 3'h6,
        CMD_OTHER = 3'h7
    } dpr_cmd_t;

    // ==========================================================
    // State machines
    typedef enum logic [2:0] {
        SUP_BROWN = 3'b001,
        SUP_WAIT = 3'b010,
        SUP_RUN = 3'b100
    } dpr_sup_t;

    typedef enum logic [3:0] {
        OUT_DRIVE = 4'b0001,
        OUT_ENTER = 4'b0010,
        OUT_DOWN = 4'b0100,
        OUT_EXIT = 4'b1000
    } dpr_out_t;

    // ==========================================================
    // Register map and field positions
    localparam logic [BUS_W-1:0] REG_STATUS = 32'h0000_0000;
    localparam logic [BUS_W-1:0] REG_VOLATILE = 32'h0000_0004;
    localparam logic [BUS_W-1:0] REG_NONVOL = 32'h0000_0008;
    localparam int ST_POWER_ON_BIT = 0;
    localparam int ST_IDLE_BIT = 1;
    localparam int ST_SERIAL_BIT = 2;
    localparam int ST_AMP_BIT = 3;
    localparam int ST_PD_LSB = 4;
    localparam int FLD_CODE_LSB = 0;
    localparam int FLD_GAIN_BIT = 16;
    localparam int FLD_PD_LSB = 17;
    localparam int FLD_REF_LSB = 19;

    // ==========================================================
    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

endpackage : dpr_pkg

// ### hdl/dpr_delay_timer.sv
// Down-counting delay timer with a one-cycle done pulse
`timescale 1ns/100ps
`default_nettype none

module dpr_delay_timer
    import dpr_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // Control
    input wire logic load,
    input wire logic [dpr_pkg::TMR_W-1:0] load_value,
    // Status
    output logic busy,
    output logic done
);

    // ==========================================================
    // Counter
    logic [TMR_W-1:0] remain;
    wire last_tick = (remain == {{(TMR_W-1){1'b0}}, 1'b1});

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            remain <= '0;
            done <= 1'b0;
        end else if (clk_en) begin
            // A fresh load restarts the wait even mid-count
            if (load) begin
                remain <= load_value;
            end else if (remain != '0) begin
                remain <= remain - 1'b1;
            end
            done <= last_tick & ~load;
        end
    end

    assign busy = (remain != '0);

endmodule : dpr_delay_timer

`default_nettype wire

// ### hdl/dpr_power_ctrl.sv
// Converter power-down and supply reset control with an AHB-Lite slave
//
// Overview of operation
// - Code loads at ack falling edge ending a write.
// - Power-on or general-call reset reloads settings from nonvolatile.
// - Power-down 00 normal, 01 1k, 10 125k, 11 640k pull-down.
// - Power-down keeps all code and configuration.
// - Power-down disables amplifier, circuits and ladder reference.
// - Leaving 00 waits entry delay before pull-down replaces drive.
// - Only six commands change volatile power-down bits.
// - Commands stay active in power-down.
// - Exit restores amplifier, ladder, reference; drops pull-down.
// - Return to 00 waits exit delay before driving.
// - Power-down clears on write with 00, wake-up, or reset with stored 00.
// - Rising supply reloads volatile from nonvolatile, starts reset timer.
// - Commands refused while release timer runs.
// - Falling supply forces power-down 11, clears the rest, refuses commands.
// - General-call reset acts as power-on without release timer.
// - One trip level: rising is power-on, falling brown-out.
// - Rising supply sets power-on flag; serial ready after timer.
// - During EEPROM write only reads are obeyed.
`timescale 1ns/100ps
`default_nettype none

module dpr_power_ctrl #(
    parameter int unsigned ENTRY_DELAY_CYCLES = dpr_pkg::POWER_DOWN_ENTRY_DELAY_CYC,
    parameter int unsigned EXIT_DELAY_CYCLES = dpr_pkg::POWER_DOWN_EXIT_DELAY_CYC,
    parameter int unsigned RESET_RELEASE_CYCLES = dpr_pkg::RESET_RELEASE_DELAY_CYC
) (
    // Clock, reset and freeze
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [dpr_pkg::BUS_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [dpr_pkg::BUS_W-1:0] hwdata,
    input wire logic hready,
    output logic [dpr_pkg::BUS_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Supply monitor and EEPROM state
    input wire logic supply_above_trip,
    input wire logic eeprom_write_idle_flag,
    // Decoded commands from the serial front end
    input wire logic cmd_done,
    input wire dpr_pkg::dpr_cmd_t cmd_kind,
    input wire logic [dpr_pkg::CODE_W-1:0] cmd_code,
    input wire logic [dpr_pkg::REF_W-1:0] cmd_ref,
    input wire logic [dpr_pkg::PD_W-1:0] cmd_pd,
    input wire logic cmd_gain,
    // Analog controls
    output logic [dpr_pkg::CODE_W-1:0] dac_code,
    output logic [dpr_pkg::REF_W-1:0] reference_source_select,
    output logic gain_double,
    output logic amp_enable,
    output logic ladder_connect,
    output logic [dpr_pkg::PD_W-1:0] pulldown_select,
    // Status
    output logic power_on_flag,
    output logic serial_ready,
    output logic cmd_refused
);

    import dpr_pkg::*;

    // ==========================================================
    // State
    dpr_sup_t sup_state;
    dpr_sup_t next_sup_state;
    dpr_out_t out_state;
    dpr_out_t next_out_state;
    logic supply_seen;
    logic [PD_W-1:0] power_down_select;
    logic [CODE_W-1:0] nv_code;
    logic [REF_W-1:0] nv_ref;
    logic [PD_W-1:0] nv_pd;
    logic nv_gain;
    logic wr_pend;
    logic [BUS_W-1:0] wr_addr;
    logic [BUS_W-1:0] rd_status;
    logic [BUS_W-1:0] rd_volatile;
    logic [BUS_W-1:0] rd_nonvol;
    logic por_done;
    logic pd_done;
    logic [TMR_W-1:0] pd_load_value;

    // ==========================================================
    // Supply crossing detection
    // one trip level
    wire supply_rise = supply_above_trip & ~supply_seen;
    wire supply_fall = ~supply_above_trip & supply_seen;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            supply_seen <= 1'b0;
        end else if (clk_en) begin
            supply_seen <= supply_above_trip;
        end
    end

    // ==========================================================
    // Supply state machine
    wire por_start = (sup_state == SUP_BROWN) & supply_rise;

    always_comb begin
        next_sup_state = sup_state;
        unique case (sup_state)
            SUP_BROWN: begin
                if (supply_rise) begin
                    next_sup_state = SUP_WAIT;
                end
            end
            SUP_WAIT: begin
                if (supply_fall) begin
                    next_sup_state = SUP_BROWN;
                end else if (por_done) begin
                    next_sup_state = SUP_RUN;
                end
            end
            SUP_RUN: begin
                if (supply_fall) begin
                    next_sup_state = SUP_BROWN;
                end
            end
            default: begin
                next_sup_state = SUP_BROWN;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sup_state <= SUP_BROWN;
        end else if (clk_en) begin
            sup_state <= next_sup_state;
        end
    end

    dpr_delay_timer u_release_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .load(por_start),
        .load_value(TMR_W'(RESET_RELEASE_CYCLES)),
        .busy(),
        .done(por_done)
    );

    // ==========================================================
    // Command acceptance
    // refused during release
    wire cmd_allowed = (sup_state == SUP_RUN) & ~supply_fall & (eeprom_write_idle_flag | (cmd_kind == CMD_READ));
    wire cmd_take = cmd_done & cmd_allowed;
    wire take_vol_dac = cmd_take & (cmd_kind == CMD_WR_VOL_DAC);
    wire take_vol_mem = cmd_take & (cmd_kind == CMD_WR_VOL_MEM);
    wire take_all_mem = cmd_take & (cmd_kind == CMD_WR_ALL_MEM);
    wire take_vol_cfg = cmd_take & (cmd_kind == CMD_WR_VOL_CFG);
    wire take_gc_reset = cmd_take & (cmd_kind == CMD_GC_RESET);
    wire take_gc_wake = cmd_take & (cmd_kind == CMD_GC_WAKE);
    wire load_code = take_vol_dac | take_vol_mem | take_all_mem;
    wire load_cfg = take_vol_mem | take_all_mem | take_vol_cfg;
    wire load_pd = load_code | take_vol_cfg;
    wire nv_reload = supply_rise | take_gc_reset;

    // ==========================================================
    // Next volatile settings
    // brown-out clear
    wire [CODE_W-1:0] next_code = supply_fall ? CODE_CLEAR :
                                  nv_reload ? nv_code :
                                  load_code ? cmd_code : dac_code;
    wire [REF_W-1:0] next_ref = supply_fall ? REF_CLEAR :
                                nv_reload ? nv_ref :
                                load_cfg ? cmd_ref : reference_source_select;
    wire next_gain = supply_fall ? 1'b0 :
                     nv_reload ? nv_gain :
                     load_cfg ? cmd_gain : gain_double;
    wire [PD_W-1:0] next_pd = supply_fall ? PD_PULL_640K :
                              nv_reload ? nv_pd :
                              take_gc_wake ? PD_NORMAL :
                              load_pd ? cmd_pd : power_down_select;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dac_code <= CODE_CLEAR;
            reference_source_select <= REF_CLEAR;
            gain_double <= 1'b0;
            power_down_select <= PD_PULL_640K;
        end else if (clk_en) begin
            dac_code <= next_code;
            reference_source_select <= next_ref;
            gain_double <= next_gain;
            power_down_select <= next_pd;
        end
    end

    // ==========================================================
    // Power flag, serial readiness and refusal pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_on_flag <= 1'b0;
            serial_ready <= 1'b0;
            cmd_refused <= 1'b0;
        end else if (clk_en) begin
            if (supply_rise) begin
                power_on_flag <= 1'b1;
            end else if (supply_fall) begin
                power_on_flag <= 1'b0;
            end
            serial_ready <= (next_sup_state == SUP_RUN);
            cmd_refused <= cmd_done & ~cmd_allowed;
        end
    end

    // ==========================================================
    // Output stage sequencing
    wire pd_selected = (power_down_select != PD_NORMAL);

    always_comb begin
        next_out_state = out_state;
        unique case (out_state)
            OUT_DRIVE: begin
                // Brown-out drops the stage at once: the supply is already gone
                if (sup_state == SUP_BROWN) begin
                    next_out_state = OUT_DOWN;
                end else if (pd_selected) begin
                    next_out_state = OUT_ENTER;
                end
            end
            OUT_ENTER: begin
                if (sup_state == SUP_BROWN) begin
                    next_out_state = OUT_DOWN;
                end else if (!pd_selected) begin
                    next_out_state = OUT_DRIVE;
                end else if (pd_done) begin
                    next_out_state = OUT_DOWN;
                end
            end
            OUT_DOWN: begin
                if (!pd_selected) begin
                    next_out_state = OUT_EXIT;
                end
            end
            OUT_EXIT: begin
                if (pd_selected) begin
                    next_out_state = OUT_DOWN;
                end else if (pd_done) begin
                    next_out_state = OUT_DRIVE;
                end
            end
            default: begin
                next_out_state = OUT_DOWN;
            end
        endcase
    end

    wire entry_start = (out_state == OUT_DRIVE) & (next_out_state == OUT_ENTER);
    wire exit_start = (out_state == OUT_DOWN) & (next_out_state == OUT_EXIT);

    assign pd_load_value = entry_start ? TMR_W'(ENTRY_DELAY_CYCLES) : TMR_W'(EXIT_DELAY_CYCLES);

    dpr_delay_timer u_pd_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .load(entry_start | exit_start),
        .load_value(pd_load_value),
        .busy(),
        .done(pd_done)
    );

    // Stage drives while running and during the entry wait
    wire next_drive = (next_out_state == OUT_DRIVE) | (next_out_state == OUT_ENTER);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_state <= OUT_DOWN;
            amp_enable <= 1'b0;
            ladder_connect <= 1'b0;
            pulldown_select <= PD_PULL_640K;
        end else if (clk_en) begin
            out_state <= next_out_state;
            amp_enable <= next_drive;
            ladder_connect <= next_drive;
            pulldown_select <= (next_out_state == OUT_DOWN) ? power_down_select : PD_NORMAL;
        end
    end

    // ==========================================================
    // AHB-Lite slave, zero wait states
    wire ahb_take = hsel & htrans[1] & hready;
    wire nv_bus_write = wr_pend & (wr_addr == REG_NONVOL);
    wire [BUS_W-1:0] rd_select = (haddr == REG_STATUS) ? rd_status :
                                 (haddr == REG_VOLATILE) ? rd_volatile :
                                 (haddr == REG_NONVOL) ? rd_nonvol : '0;

    always_comb begin
        rd_status = '0;
        rd_status[ST_POWER_ON_BIT] = power_on_flag;
        rd_status[ST_IDLE_BIT] = eeprom_write_idle_flag;
        rd_status[ST_SERIAL_BIT] = serial_ready;
        rd_status[ST_AMP_BIT] = amp_enable;
        rd_status[ST_PD_LSB +: PD_W] = pulldown_select;
        rd_volatile = '0;
        rd_volatile[FLD_CODE_LSB +: CODE_W] = dac_code;
        rd_volatile[FLD_GAIN_BIT] = gain_double;
        rd_volatile[FLD_PD_LSB +: PD_W] = power_down_select;
        rd_volatile[FLD_REF_LSB +: REF_W] = reference_source_select;
        rd_nonvol = '0;
        rd_nonvol[FLD_CODE_LSB +: CODE_W] = nv_code;
        rd_nonvol[FLD_GAIN_BIT] = nv_gain;
        rd_nonvol[FLD_PD_LSB +: PD_W] = nv_pd;
        rd_nonvol[FLD_REF_LSB +: REF_W] = nv_ref;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end else if (clk_en) begin
            wr_pend <= ahb_take & hwrite;
            if (ahb_take) begin
                wr_addr <= haddr;
            end
            // Read data captured at address phase, from a flop
            if (ahb_take & ~hwrite) begin
                hrdata <= rd_select;
            end
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
    end

    // ==========================================================
    // Nonvolatile image; the write-all command wins over a bus write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nv_code <= CODE_CLEAR;
            nv_ref <= REF_CLEAR;
            nv_pd <= NV_PD_RESET;
            nv_gain <= 1'b0;
        end else if (clk_en) begin
            if (take_all_mem) begin
                nv_code <= cmd_code;
                nv_ref <= cmd_ref;
                nv_pd <= cmd_pd;
                nv_gain <= cmd_gain;
            end else if (nv_bus_write) begin
                nv_code <= hwdata[FLD_CODE_LSB +: CODE_W];
                nv_ref <= hwdata[FLD_REF_LSB +: REF_W];
                nv_pd <= hwdata[FLD_PD_LSB +: PD_W];
                nv_gain <= hwdata[FLD_GAIN_BIT];
            end
        end
    end

endmodule : dpr_power_ctrl

`default_nettype wire

// ### test/dpr_cmd_master.sv
// Serial master model issuing decoded commands
`timescale 1ns/100ps
`default_nettype none

module dpr_cmd_master
    import dpr_pkg::*;
(
    // Clock
    input wire logic hclk,
    // Decoded command
    output logic cmd_done,
    output dpr_pkg::dpr_cmd_t cmd_kind,
    output logic [dpr_pkg::CODE_W-1:0] cmd_code,
    output logic [dpr_pkg::REF_W-1:0] cmd_ref,
    output logic [dpr_pkg::PD_W-1:0] cmd_pd,
    output logic cmd_gain
);
    initial begin
        {cmd_done, cmd_code, cmd_ref, cmd_pd, cmd_gain} = '0;
        cmd_kind = CMD_OTHER;
    end

    // ==========================================================
    // One frame, done marks the ack falling edge
    // Fields invert after the frame so stale values never help
    task send(input dpr_cmd_t k, logic [CODE_W-1:0] c, logic [PD_W-1:0] p, logic [REF_W-1:0] r, logic g);
        @(posedge hclk);
        cmd_done <= 1'b1;
        cmd_kind <= k;
        {cmd_code, cmd_pd, cmd_ref, cmd_gain} <= {c, p, r, g};
        @(posedge hclk);
        cmd_done <= 1'b0;
        cmd_kind <= dpr_cmd_t'(~k);
        {cmd_code, cmd_pd, cmd_ref, cmd_gain} <= ~{c, p, r, g};
    endtask : send
endmodule : dpr_cmd_master

`default_nettype wire

// ### test/dpr_power_ctrl_sva.sv
// Assertion checker for the converter power and reset control block
`timescale 1ns/100ps
`default_nettype none

module dpr_power_ctrl_sva
    import dpr_pkg::*;
#(
    parameter int unsigned ENTRY_DELAY_CYCLES = 4,
    parameter int unsigned EXIT_DELAY_CYCLES = 6,
    parameter int unsigned RESET_RELEASE_CYCLES = 10
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Inputs
    input wire logic supply_above_trip,
    input wire logic eeprom_write_idle_flag,
    input wire logic cmd_done,
    input wire dpr_pkg::dpr_cmd_t cmd_kind,
    input wire logic [dpr_pkg::CODE_W-1:0] cmd_code,
    // Outputs
    input wire logic [dpr_pkg::CODE_W-1:0] dac_code,
    input wire logic amp_enable,
    input wire logic ladder_connect,
    input wire logic [dpr_pkg::PD_W-1:0] pulldown_select,
    input wire logic power_on_flag,
    input wire logic serial_ready,
    input wire logic cmd_refused
);
    logic amp_q;
    logic [15:0] run_cnt;
    wire acc = cmd_done && serial_ready && eeprom_write_idle_flag && supply_above_trip;

    // ==========================================================
    // Cycles amplifier level has stood, saturating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            amp_q <= 1'b0;
            run_cnt <= 16'h0000;
        end else begin
            amp_q <= amp_enable;
            run_cnt <= (amp_enable != amp_q) ? 16'h0000 : run_cnt + {15'h0000, ~&run_cnt};
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_cmd_load;
        acc && cmd_kind == CMD_WR_VOL_DAC |=> dac_code == $past(cmd_code);
    endproperty
    a_cmd_load: assert property (p_cmd_load) else $error("code not loaded");
    property p_refuse;
        cmd_done && !serial_ready && $stable(supply_above_trip) |=> cmd_refused && $stable(dac_code);
    endproperty
    a_refuse: assert property (p_refuse) else $error("command taken before ready");
    property p_busy;
        cmd_done && serial_ready && supply_above_trip && !eeprom_write_idle_flag && cmd_kind != CMD_READ
            |=> cmd_refused && $stable(dac_code);
    endproperty
    a_busy: assert property (p_busy) else $error("command taken while writing");
    property p_fall;
        $fell(supply_above_trip) |=> dac_code == CODE_CLEAR && !power_on_flag && !serial_ready ##1 !amp_enable;
    endproperty
    a_fall: assert property (p_fall) else $error("brown-out effects missing");
    property p_rise;
        $rose(supply_above_trip) |=> (power_on_flag && !serial_ready) [*8] ##[1:1000] serial_ready;
    endproperty
    a_rise: assert property (p_rise) else $error("power-on sequence wrong");
    property p_entry;
        $fell(amp_enable) && supply_above_trip && $past(supply_above_trip) && $past(supply_above_trip, 2)
            |-> run_cnt >= ENTRY_DELAY_CYCLES - 1;
    endproperty
    a_entry: assert property (p_entry) else $error("entry delay too short");
    property p_exit;
        $rose(amp_enable) |-> run_cnt >= EXIT_DELAY_CYCLES - 1;
    endproperty
    a_exit: assert property (p_exit) else $error("exit delay too short");
    property p_pull;
        amp_enable == ladder_connect && (pulldown_select == PD_NORMAL || !amp_enable);
    endproperty
    a_pull: assert property (p_pull) else $error("pull-down while driving");
    property p_wake;
        acc && cmd_kind == CMD_GC_WAKE && pulldown_select != PD_NORMAL |-> ##[1:1000] amp_enable;
    endproperty
    a_wake: assert property (p_wake) else $error("wake-up did not drive");
endmodule : dpr_power_ctrl_sva

bind dpr_power_ctrl dpr_power_ctrl_sva #(.ENTRY_DELAY_CYCLES(ENTRY_DELAY_CYCLES),
    .EXIT_DELAY_CYCLES(EXIT_DELAY_CYCLES), .RESET_RELEASE_CYCLES(RESET_RELEASE_CYCLES)) u_sva (.*);

`default_nettype wire

// ### test/dpr_power_ctrl_tb.sv
// Self-checking testbench for the converter power and reset control block
`timescale 1ns/100ps
`default_nettype none

module dpr_power_ctrl_tb;
    import dpr_pkg::*;
    localparam int ENT = 4;
    localparam int EXT = 6;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, sup, idle, g, gain_o, amp_enable;
    logic ladder_connect, power_on_flag, serial_ready, cmd_refused, cmd_done, cmd_gain;
    logic [1:0] htrans, rsel, ref_o, cmd_ref, cmd_pd, pulldown_select;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [11:0] code, cmd_code, dac_code;
    dpr_cmd_t cmd_kind;
    int err_total, n_checks, seed, n;
    assign hready = hreadyout;

    dpr_power_ctrl #(.ENTRY_DELAY_CYCLES(ENT), .EXIT_DELAY_CYCLES(EXT), .RESET_RELEASE_CYCLES(10)) uut (
        .hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .supply_above_trip(sup), .eeprom_write_idle_flag(idle), .cmd_done,
        .cmd_kind, .cmd_code, .cmd_ref, .cmd_pd, .cmd_gain, .dac_code, .reference_source_select(ref_o),
        .gain_double(gain_o), .amp_enable, .ladder_connect, .pulldown_select, .power_on_flag, .serial_ready,
        .cmd_refused);
    dpr_cmd_master u_mst (.hclk, .cmd_done, .cmd_kind, .cmd_code, .cmd_ref, .cmd_pd, .cmd_gain);

    function automatic logic [31:0] pk(input logic [11:0] c, logic gn, logic [1:0] p, r);
        return {11'h000, r, p, gn, 4'h0, c};
    endfunction : pk
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    task chk(input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // A wait that runs out counts as a mismatch
    task lim(input logic bad);
        if (bad) begin
            err_total++;
            close_out();
        end
    endtask : lim
    task automatic wfor(ref logic s, input logic v, output int c);
        c = 0;
        while (s !== v && c < 3000) begin
            @(posedge hclk);
            #1;
            c++;
        end
        lim(s !== v);
    endtask : wfor
    // Wait for hready high at a rising edge
    task rdy;
        int c;
        c = 0;
        do begin
            @(posedge hclk);
            c++;
        end while (hready !== 1'b1 && c < 50);
        lim(hready !== 1'b1);
    endtask : rdy
    task ahb(input logic w, logic [31:0] a, d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= a;
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        rd = hrdata;
    endtask : ahb
    task cmd(input dpr_cmd_t k, logic [1:0] p);
        u_mst.send(k, code, p, rsel, g);
        #1;
    endtask : cmd

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    initial begin
        {hresetn, hsel, htrans, hwrite, haddr, hwdata, sup, g, rsel, err_total, n_checks} = '0;
        idle = 1'b1;
        seed = 91;
        code = 12'($random(seed));
        {g, rsel} = 3'($random(seed));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        chk({amp_enable, pulldown_select, serial_ready, hresp, hreadyout}, {1'b0, PD_PULL_640K, 2'h0, 1'b1});
        ahb(1'b1, REG_NONVOL, pk(code, g, PD_NORMAL, rsel));
        cmd(CMD_WR_VOL_DAC, PD_NORMAL);
        chk(cmd_refused, 1'b1);
        sup <= 1'b1;
        @(posedge hclk);
        #1;
        chk({power_on_flag, dac_code, gain_o, ref_o}, {1'b1, code, g, rsel});
        cmd(CMD_WR_VOL_DAC, PD_NORMAL);
        chk(cmd_refused, 1'b1);
        // Master waits for reset to complete
        wfor(serial_ready, 1'b1, n);
        wfor(amp_enable, 1'b1, n);
        chk(ladder_connect, 1'b1);
        repeat (6) begin
            code = 12'($random(seed));
            cmd(CMD_WR_VOL_DAC, PD_NORMAL);
            chk(dac_code, code);
        end
        for (int i = 1; i < 4; i++) begin
            cmd(CMD_WR_VOL_DAC, i[1:0]);
            wfor(amp_enable, 1'b0, n);
            chk(n >= ENT, 1'b1);
            chk(pulldown_select, i[1:0]);
            ahb(1'b0, REG_VOLATILE, 32'h0);
            chk(rd, pk(code, g, i[1:0], rsel));
            cmd(i == 1 ? CMD_GC_WAKE : (i == 2 ? CMD_WR_VOL_CFG : CMD_WR_VOL_MEM), PD_NORMAL);
            chk(cmd_refused, 1'b0);
            wfor(amp_enable, 1'b1, n);
            chk({n >= EXT, pulldown_select}, {1'b1, PD_NORMAL});
        end
        cmd(CMD_READ, PD_PULL_1K);
        cmd(CMD_OTHER, PD_PULL_1K);
        repeat (ENT + 4) @(posedge hclk);
        chk(amp_enable, 1'b1);
        idle <= 1'b0;
        u_mst.send(CMD_WR_VOL_DAC, ~code, PD_NORMAL, rsel, g);
        #1;
        chk({cmd_refused, dac_code}, {1'b1, code});
        cmd(CMD_READ, PD_NORMAL);
        chk(cmd_refused, 1'b0);
        idle <= 1'b1;
        code = 12'($random(seed));
        ahb(1'b1, REG_NONVOL, pk(code, g, PD_PULL_1K, rsel));
        cmd(CMD_GC_RESET, PD_NORMAL);
        chk({dac_code, serial_ready}, {code, 1'b1});
        wfor(amp_enable, 1'b0, n);
        chk(pulldown_select, PD_PULL_1K);
        cmd(CMD_WR_ALL_MEM, PD_NORMAL);
        wfor(amp_enable, 1'b1, n);
        ahb(1'b0, REG_NONVOL, 32'h0);
        chk(rd, pk(code, g, PD_NORMAL, rsel));
        sup <= 1'b0;
        @(posedge hclk);
        #1;
        chk({dac_code, power_on_flag, serial_ready}, 14'h0000);
        @(posedge hclk);
        #1;
        chk({amp_enable, pulldown_select}, {1'b0, PD_PULL_640K});
        ahb(1'b0, REG_VOLATILE, 32'h0);
        chk(rd, pk(CODE_CLEAR, 1'b0, PD_PULL_640K, REF_CLEAR));
        ahb(1'b0, 32'h0000_0010, 32'h0);
        chk(rd, 32'h0000_0000);
        close_out();
    end
endmodule : dpr_power_ctrl_tb

`default_nettype wire
